// File: logic/wsf_debounce.sv
`timescale 1ns/1ns
module wsf_debounce #(
    parameter int SAMPLES = 32
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic tick,
    input  wire logic pin,
    output logic      valid_high
);
    logic [7:0] run;
    wire        full = (run >= 8'(SAMPLES));

    // any low sample restarts the run, so a glitch costs a full window
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run        <= 8'h0;
            valid_high <= 1'b0;
        end else if (tick) begin
            if (!pin) begin
                run        <= 8'h0;
                valid_high <= 1'b0;
            end else if (!full) begin
                run        <= run + 8'h1;
                valid_high <= (run + 8'h1 >= 8'(SAMPLES));
            end
        end
    end
endmodule

// File: logic/wsf_pkg.sv
package wsf_pkg;

    // register byte addresses
    localparam logic [15:0] ADDR_RESET_CAUSE  = 16'h28b0;
    localparam logic [15:0] ADDR_WAKE_FLAGS   = 16'h28b1;
    localparam logic [15:0] ADDR_TIMER_ARM    = 16'h28b2;
    localparam logic [15:0] ADDR_WAKE_ENABLES = 16'h28b3;
    localparam logic [15:0] ADDR_TIMER_RELOAD = 16'h2880;
    localparam logic [15:0] ADDR_SOFT_RESET   = 16'h2200;
    localparam logic [15:0] ADDR_OPTICAL_CFG  = 16'h2457;

    // reset cause field positions
    localparam int RC_COLD_START  = 7;
    localparam int RC_RESET_PIN   = 6;
    localparam int RC_SOFT_RESET  = 5;
    localparam int RC_WATCHDOG    = 4;
    localparam int RC_DEBUG_RESET = 3;
    localparam int RC_LOW_BATTERY = 2;

    // wake flag / enable field positions
    localparam int WF_TIMER  = 5;
    localparam int WF_SERIAL = 4;
    localparam int WF_BUTTON = 3;
    localparam int WF_PIN_A  = 2;
    localparam int WF_PIN_B  = 1;
    localparam int WF_PIN_C  = 0;

    // control field positions
    localparam int CTL_SLEEP    = 7;
    localparam int CTL_LCD_ONLY = 6;
    localparam int CTL_ARM      = 5;
    localparam int CTL_SOFT_RST = 3;
    localparam int CTL_OPT_DIS  = 2;

    localparam logic [7:0] RESET_ZERO = 8'h00;

    // debounce timing
    localparam int CLK_HZ         = 25000000;
    localparam int SAMPLE_MS      = 2;
    localparam int STABLE_MS      = 64;
    localparam int SAMPLE_CYCLES  = (CLK_HZ / 1000) * SAMPLE_MS;
    localparam int STABLE_SAMPLES = STABLE_MS / SAMPLE_MS;

endpackage

// File: logic/wsf_tick.sv
`timescale 1ns/1ns
module wsf_tick #(
    parameter int PERIOD = 50000
) (
    input  wire logic clk,
    input  wire logic nrst,
    output logic      tick
);
    logic [31:0] count;
    wire         wrap = (count == 32'(PERIOD - 1));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= 32'h0;
            tick  <= 1'b0;
        end else begin
            count <= wrap ? 32'h0 : count + 32'h1;
            tick  <= wrap;
        end
    end
endmodule

// File: logic/wsf_top.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module wsf_top #(
    parameter int  SAMPLE_CYCLES  = wsf_pkg::SAMPLE_CYCLES,
    parameter int  STABLE_SAMPLES = wsf_pkg::STABLE_SAMPLES,
    parameter bit  LARGE_PACKAGE  = 1'b1
) (
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    input  wire logic        MULTI_PIN_A,
    input  wire logic        MULTI_PIN_B,
    input  wire logic        MULTI_PIN_C,
    input  wire logic        PIN_A_IS_INPUT,
    input  wire logic        PIN_B_IS_INPUT,
    input  wire logic        PIN_C_IS_INPUT,
    input  wire logic        PUSH_BUTTON_IN,
    input  wire logic        SERIAL_RX_IN,
    input  wire logic        OPTICAL_RX_IN,
    input  wire logic        TIMER_EXPIRED,
    input  wire logic        RESET_PIN_EVENT,
    input  wire logic        DEBUG_RESET_IN,
    input  wire logic        DEBUG_PORT_ENABLE,
    input  wire logic        WATCHDOG_EVENT,
    input  wire logic        COLD_START_EVENT,
    input  wire logic        LOW_BATTERY_EVENT,
    output logic             WAKE,
    output logic             TIMER_LOAD,
    output logic      [7:0]  TIMER_LOAD_VALUE,
    output logic             TIMER_ACTIVE,
    output logic             SOFT_RESET_REQ
);

    ////////////////////////////////////////////////////////////////////////////
    // registers and bus decode

    logic [7:0] wake_enables;
    logic [7:0] timer_reload_value;
    logic       timer_armed;
    logic       optical_rx_disable;
    logic [7:0] reset_cause;
    logic [7:0] wake_flags;

    wire wr_enables = WR && (ADDR == wsf_pkg::ADDR_WAKE_ENABLES);
    wire wr_control = WR && (ADDR == wsf_pkg::ADDR_TIMER_ARM);
    wire wr_reload  = WR && (ADDR == wsf_pkg::ADDR_TIMER_RELOAD);
    wire wr_soft    = WR && (ADDR == wsf_pkg::ADDR_SOFT_RESET);
    wire wr_optical = WR && (ADDR == wsf_pkg::ADDR_OPTICAL_CFG);

    wire en_pin_a_wake     = wake_enables[wsf_pkg::WF_PIN_A];
    wire en_pin_b_wake     = wake_enables[wsf_pkg::WF_PIN_B];
    wire en_pin_c_wake     = wake_enables[wsf_pkg::WF_PIN_C];
    wire en_button_wake    = wake_enables[wsf_pkg::WF_BUTTON];
    wire en_serial_rx_wake = wake_enables[wsf_pkg::WF_SERIAL];

    wire sleep_req = wr_control && (WDATA[wsf_pkg::CTL_SLEEP] || WDATA[wsf_pkg::CTL_LCD_ONLY]);
    wire arm_req   = wr_control && WDATA[wsf_pkg::CTL_ARM];
    wire soft_req  = wr_soft && WDATA[wsf_pkg::CTL_SOFT_RST];

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            wake_enables       <= wsf_pkg::RESET_ZERO;
            timer_reload_value <= wsf_pkg::RESET_ZERO;
            timer_armed        <= 1'b0;
            optical_rx_disable <= 1'b0;
        end else begin
            if (wr_enables) begin
                wake_enables <= WDATA & 8'h1f;
            end
            if (wr_reload) begin
                timer_reload_value <= WDATA;
            end
            if (wr_control) begin
                timer_armed <= WDATA[wsf_pkg::CTL_ARM];
            end
            if (wr_optical) begin
                optical_rx_disable <= WDATA[wsf_pkg::CTL_OPT_DIS];
            end
        end
    end

    wire [7:0] control_rd = {2'h0, timer_armed, 5'h0};
    wire [7:0] optical_rd = {5'h0, optical_rx_disable, 2'h0};
    wire [7:0] read_mux =
        (ADDR == wsf_pkg::ADDR_RESET_CAUSE)  ? reset_cause        :
        (ADDR == wsf_pkg::ADDR_WAKE_FLAGS)   ? wake_flags         :
        (ADDR == wsf_pkg::ADDR_TIMER_ARM)    ? control_rd         :
        (ADDR == wsf_pkg::ADDR_WAKE_ENABLES) ? wake_enables       :
        (ADDR == wsf_pkg::ADDR_TIMER_RELOAD) ? timer_reload_value :
        (ADDR == wsf_pkg::ADDR_OPTICAL_CFG)  ? optical_rd         :
        8'h00;

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= RD ? read_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // debounce of level-sensitive pins

    logic sample_tick;
    logic pb_valid;
    logic pin_b_valid;
    logic pin_c_valid;

    wsf_tick #(.PERIOD(SAMPLE_CYCLES)) u_tick (
        .clk  (CLK_SYS),
        .nrst (NRST),
        .tick (sample_tick)
    );

    wsf_debounce #(.SAMPLES(STABLE_SAMPLES)) u_db_pb (
        .clk        (CLK_SYS),
        .nrst       (NRST),
        .tick       (sample_tick),
        .pin        (PUSH_BUTTON_IN),
        .valid_high (pb_valid)
    );

    wsf_debounce #(.SAMPLES(STABLE_SAMPLES)) u_db_b (
        .clk        (CLK_SYS),
        .nrst       (NRST),
        .tick       (sample_tick),
        .pin        (MULTI_PIN_B),
        .valid_high (pin_b_valid)
    );

    wsf_debounce #(.SAMPLES(STABLE_SAMPLES)) u_db_c (
        .clk        (CLK_SYS),
        .nrst       (NRST),
        .tick       (sample_tick),
        .pin        (MULTI_PIN_C),
        .valid_high (pin_c_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // wake source qualification

    logic pin_a_d;
    logic serial_d;
    logic optical_d;

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            pin_a_d   <= 1'b0;
            serial_d  <= 1'b0;
            optical_d <= 1'b0;
        end else begin
            pin_a_d   <= MULTI_PIN_A;
            serial_d  <= SERIAL_RX_IN;
            optical_d <= OPTICAL_RX_IN;
        end
    end

    wire pin_a_cfg = en_pin_a_wake && PIN_A_IS_INPUT;
    wire pin_b_cfg = en_pin_b_wake && PIN_B_IS_INPUT && LARGE_PACKAGE;
    wire pin_c_cfg = en_pin_c_wake && (PIN_C_IS_INPUT || !optical_rx_disable);

    wire ev_pin_a  = pin_a_cfg && MULTI_PIN_A && !pin_a_d;
    wire ev_pin_b  = pin_b_cfg && pin_b_valid;
    wire opt_edge  = OPTICAL_RX_IN ^ optical_d;
    wire ev_pin_c  = pin_c_cfg && (optical_rx_disable ? pin_c_valid : opt_edge);
    wire ev_button = en_button_wake && pb_valid;
    wire ev_serial = en_serial_rx_wake && (SERIAL_RX_IN ^ serial_d);
    wire ev_timer  = TIMER_EXPIRED && TIMER_ACTIVE;

    wire any_wake = ev_pin_a || ev_pin_b || ev_pin_c || ev_button || ev_serial || ev_timer;

    // wake falls on a sleep request; a same-cycle wake event keeps it high
    wire next_wake = any_wake ? 1'b1 : (sleep_req ? 1'b0 : WAKE);
    wire wake_fall = WAKE && !next_wake;

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            WAKE             <= 1'b1;
            TIMER_LOAD       <= 1'b0;
            TIMER_LOAD_VALUE <= 8'h00;
            TIMER_ACTIVE     <= 1'b0;
            SOFT_RESET_REQ   <= 1'b0;
        end else begin
            WAKE             <= next_wake;
            TIMER_LOAD       <= arm_req;
            TIMER_LOAD_VALUE <= timer_reload_value;
            if (sleep_req && (timer_armed || arm_req)) begin
                TIMER_ACTIVE <= 1'b1;
            end else if (ev_timer || (wr_control && !WDATA[wsf_pkg::CTL_ARM])) begin
                TIMER_ACTIVE <= 1'b0;
            end
            SOFT_RESET_REQ   <= soft_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake flags: set wins over clear, a low pin a/b/c config holds that pin flag clear

    wire [7:0] wake_set = {2'h0, ev_timer, ev_serial, ev_button,
                           ev_pin_a, ev_pin_b, ev_pin_c};
    // button flag sets on a press even while awake
    wire [7:0] wake_hold = {2'h0, 3'h7, pin_a_cfg, pin_b_cfg, pin_c_cfg};
    wire [7:0] keep_wake = wake_fall ? 8'h00 : wake_flags;
    wire [7:0] next_wake_flags = (keep_wake | wake_set) & wake_hold;

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            wake_flags <= wsf_pkg::RESET_ZERO;
        end else begin
            wake_flags <= next_wake_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset cause flags: a new cause clears the others, but debug clears none, low battery leaves debug set, and low battery clears only on wake fall

    wire set_cs  = COLD_START_EVENT;
    wire set_rp  = RESET_PIN_EVENT;
    wire set_sr  = soft_req;
    wire set_wd  = WATCHDOG_EVENT;
    wire set_dbg = DEBUG_RESET_IN && DEBUG_PORT_ENABLE;
    wire set_lb  = LOW_BATTERY_EVENT;

    wire clr_rp  = wake_fall || set_cs || set_sr || set_wd || set_lb;
    wire clr_sr  = wake_fall || set_cs || set_wd || set_lb || set_rp;
    wire clr_cs  = wake_fall || set_sr || set_wd || set_lb || set_rp;
    wire clr_wd  = wake_fall || set_cs || set_sr || set_lb || set_rp;
    wire clr_dbg = wake_fall || set_cs || set_rp || set_wd || set_sr;
    wire clr_lb  = wake_fall;

    function automatic logic flag_next(input logic cur, input logic set, input logic clr);
        flag_next = set | (cur & ~clr);
    endfunction

    wire [7:0] next_reset_cause = {
        flag_next(reset_cause[wsf_pkg::RC_COLD_START],  set_cs,  clr_cs),
        flag_next(reset_cause[wsf_pkg::RC_RESET_PIN],   set_rp,  clr_rp),
        flag_next(reset_cause[wsf_pkg::RC_SOFT_RESET],  set_sr,  clr_sr),
        flag_next(reset_cause[wsf_pkg::RC_WATCHDOG],    set_wd,  clr_wd),
        flag_next(reset_cause[wsf_pkg::RC_DEBUG_RESET], set_dbg, clr_dbg),
        flag_next(reset_cause[wsf_pkg::RC_LOW_BATTERY], set_lb,  clr_lb),
        2'h0
    };

    // flags survive NRST only in a real non-volatile cell; here reset clears
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            reset_cause <= wsf_pkg::RESET_ZERO;
        end else begin
            reset_cause <= next_reset_cause;
        end
    end

endmodule

// File: test/tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    localparam logic [15:0] A_FLG = wsf_pkg::ADDR_WAKE_FLAGS;
    localparam logic [15:0] A_CAU = wsf_pkg::ADDR_RESET_CAUSE;
    localparam logic [15:0] A_CTL = wsf_pkg::ADDR_TIMER_ARM;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [2:0]  is_in = 3'h0;
    logic [5:0]  want = 6'h00;
    logic [5:0]  pins;
    logic        tmr_exp = 1'b0;
    logic [5:0]  ev = 6'h00;
    logic [7:0]  rdata;
    logic [7:0]  tval;
    logic        wake;
    logic        tload;
    logic        tact;
    logic        srst;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    wsf_pins u_wsf_pins (.clk(clk), .want(want), .pins(pins));
    wsf_top #(.SAMPLE_CYCLES(4), .STABLE_SAMPLES(3)) u_wsf_top (
        .CLK_SYS(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .MULTI_PIN_A(pins[0]), .MULTI_PIN_B(pins[1]), .MULTI_PIN_C(pins[2]),
        .PIN_A_IS_INPUT(is_in[0]), .PIN_B_IS_INPUT(is_in[1]), .PIN_C_IS_INPUT(is_in[2]),
        .PUSH_BUTTON_IN(pins[3]), .SERIAL_RX_IN(pins[4]), .OPTICAL_RX_IN(pins[5]),
        .TIMER_EXPIRED(tmr_exp), .RESET_PIN_EVENT(ev[0]), .DEBUG_RESET_IN(ev[1]),
        .DEBUG_PORT_ENABLE(ev[2]), .WATCHDOG_EVENT(ev[3]), .COLD_START_EVENT(ev[4]),
        .LOW_BATTERY_EVENT(ev[5]), .WAKE(wake), .TIMER_LOAD(tload),
        .TIMER_LOAD_VALUE(tval), .TIMER_ACTIVE(tact), .SOFT_RESET_REQ(srst));
    initial forever #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic results;
        if (num_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // whole run needs well under 1000 cycles; the ceiling leaves room
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            results();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask
    task automatic rd8(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata, exp)
    endtask
    task automatic put(input logic [5:0] w, input logic [2:0] i);
        @(posedge clk);
        want  <= w;
        is_in <= i;
    endtask
    task automatic evp(input logic [5:0] e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= 6'h00;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        `CHK(wake, 1'b1)
        rd8(A_CAU, 8'h00);
        rd8(wsf_pkg::ADDR_WAKE_ENABLES, 8'h00);
        wr8(A_FLG, 8'hff);
        wr8(A_CAU, 8'hff);
        rd8(A_FLG, 8'h00);
        rd8(A_CAU, 8'h00);
        rd8(16'h0000, 8'h00);
        // serial idles high before its wake path is enabled
        put(6'h10, 3'h0);
    endtask
    task automatic t_timer;
        wr8(wsf_pkg::ADDR_TIMER_RELOAD, 8'h5a);
        rd8(wsf_pkg::ADDR_TIMER_RELOAD, 8'h5a);
        wr8(A_CTL, 8'h20);
        `CHK({tload, tval}, 9'h15a)
        rd8(A_CTL, 8'h20);
        wr8(A_CTL, 8'ha0);
        `CHK({wake, tact}, 2'b01)
        cyc(5);
        `CHK(wake, 1'b0)
        @(posedge clk);
        tmr_exp <= 1'b1;
        @(posedge clk);
        tmr_exp <= 1'b0;
        cyc(2);
        `CHK(wake, 1'b1)
        rd8(A_FLG, 8'h20);
    endtask
    task automatic t_causes;
        // zero stands for a soft reset write instead of an event pulse
        logic [5:0] evs [9] = '{6'h10, 6'h08, 6'h01, 6'h02, 6'h06, 6'h00, 6'h20, 6'h10, 6'h01};
        logic [7:0] exs [9] = '{8'h80, 8'h10, 8'h40, 8'h40, 8'h48, 8'h20, 8'h04, 8'h84, 8'h44};
        for (int i = 0; i < 9; i++) begin
            if (evs[i] == 6'h00)
                wr8(wsf_pkg::ADDR_SOFT_RESET, 8'h08);
            else
                evp(evs[i]);
            rd8(A_CAU, exs[i]);
        end
        wr8(wsf_pkg::ADDR_SOFT_RESET, 8'h08);
        `CHK(srst, 1'b1)
        rd8(wsf_pkg::ADDR_SOFT_RESET, 8'h00);
        rd8(A_CAU, 8'h24);
        wr8(A_CTL, 8'h80);
        rd8(A_CAU, 8'h00);
    endtask
    task automatic t_level;
        wr8(wsf_pkg::ADDR_OPTICAL_CFG, 8'h04);
        wr8(wsf_pkg::ADDR_WAKE_ENABLES, 8'h1f);
        rd8(wsf_pkg::ADDR_WAKE_ENABLES, 8'h1f);
        put(6'h1e, 3'h7);
        cyc(4);
        rd8(A_FLG, 8'h00);
        cyc(20);
        `CHK(wake, 1'b1)
        rd8(A_FLG, 8'h0b);
        // b and c stay high but stop being inputs; button released
        put(6'h16, 3'h0);
        cyc(2);
        rd8(A_FLG, 8'h08);
        put(6'h10, 3'h0);
        wr8(A_CTL, 8'h80);
        `CHK(wake, 1'b0)
        rd8(A_FLG, 8'h00);
    endtask
    task automatic t_edge;
        wr8(wsf_pkg::ADDR_OPTICAL_CFG, 8'h00);
        put(6'h30, 3'h1);
        cyc(3);
        `CHK(wake, 1'b1)
        put(6'h21, 3'h1);
        cyc(3);
        rd8(A_FLG, 8'h15);
        put(6'h20, 3'h0);
        // display-only entry must drop wake just like sleep
        wr8(A_CTL, 8'h40);
        put(6'h21, 3'h0);
        cyc(3);
        `CHK(wake, 1'b0)
        rd8(A_FLG, 8'h00);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        cyc(1);
        t_regs();
        t_timer();
        t_causes();
        t_level();
        t_edge();
        results();
    end
endmodule

// File: test/wsf_checker_assertions.sv
`timescale 1ns/1ns
module wsf_checker (
    input wire logic        CLK_SYS,
    input wire logic        NRST,
    input wire logic [15:0] ADDR,
    input wire logic [7:0]  WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    input wire logic        TIMER_EXPIRED,
    input wire logic        DEBUG_RESET_IN,
    input wire logic        DEBUG_PORT_ENABLE,
    input wire logic        WAKE,
    input wire logic        TIMER_LOAD,
    input wire logic [7:0]  TIMER_LOAD_VALUE,
    input wire logic        TIMER_ACTIVE,
    input wire logic        SOFT_RESET_REQ
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////////////////////////////////////////
    // shadows rebuilt from the bus and the debug pins alone, so the checker never peeks inside
    logic [7:0] en;
    logic [7:0] en_d;
    logic [7:0] reload;
    logic       armed;
    logic       dbg_seen;
    wire        wr_arm   = WR && (ADDR == wsf_pkg::ADDR_TIMER_ARM);
    wire        arm_set  = wr_arm && WDATA[5];
    wire        wr_en    = WR && (ADDR == wsf_pkg::ADDR_WAKE_ENABLES);
    wire        wr_rel   = WR && (ADDR == wsf_pkg::ADDR_TIMER_RELOAD);
    wire        rd_flags = RD && (ADDR == wsf_pkg::ADDR_WAKE_FLAGS);
    wire        rd_cause = RD && (ADDR == wsf_pkg::ADDR_RESET_CAUSE);
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            en       <= 8'h00;
            en_d     <= 8'h00;
            reload   <= 8'h00;
            armed    <= 1'b0;
            dbg_seen <= 1'b0;
        end else begin
            en       <= wr_en ? WDATA : en;
            en_d     <= en;
            reload   <= wr_rel ? WDATA : reload;
            armed    <= wr_arm ? WDATA[5] : armed;
            dbg_seen <= dbg_seen | (DEBUG_RESET_IN & DEBUG_PORT_ENABLE);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_pin_a_held: assert property (rd_flags && !en[2] && !en_d[2] |=> !RDATA[2])
        else $error("pin a flag seen while its wake is off");
    a_timer_load: assert property (TIMER_LOAD == $past(arm_set))
        else $error("timer load pulse not tied to arm write");
    a_load_value: assert property ($rose(TIMER_LOAD) |-> TIMER_LOAD_VALUE == reload)
        else $error("timer load value differs from reload");
    a_timer_active: assert property (wr_arm && WDATA[7] && WDATA[5] && armed
        && !TIMER_EXPIRED |=> TIMER_ACTIVE)
        else $error("armed timer not active after sleep");
    a_timer_wakes: assert property (TIMER_ACTIVE && TIMER_EXPIRED |-> ##[1:2] WAKE)
        else $error("timer expiry did not wake");
    a_sleep_wake: assert property (wr_arm && WDATA[7] && en[4:0] == 5'h00
        && !TIMER_EXPIRED |=> !WAKE [*2])
        else $error("wake did not fall on sleep");
    a_soft_req: assert property (WR && ADDR == wsf_pkg::ADDR_SOFT_RESET && WDATA[3]
        |=> SOFT_RESET_REQ ##1 !SOFT_RESET_REQ)
        else $error("soft reset request not a single pulse");
    a_soft_reads: assert property (RD && ADDR == wsf_pkg::ADDR_SOFT_RESET |=> RDATA == 8'h00)
        else $error("soft reset address read back nonzero");
    a_debug_qual: assert property (rd_cause && !dbg_seen |=> !RDATA[3])
        else $error("debug flag without enabled debug reset");
endmodule

bind wsf_top wsf_checker u_wsf_checker (.*);

// File: test/wsf_pins.sv
`timescale 1ns/1ns
// far side: pins follow each request one clock later; bit order is
// a, b, c, button, serial, optical. levels only, no pad bounce modelled
module wsf_pins (
    input  wire logic       clk,
    input  wire logic [5:0] want,
    output logic      [5:0] pins
);
    initial pins = 6'h00;
    always @(posedge clk) pins <= want;
endmodule
